// ### rtl/dpsc_pkg.sv
// Package for drive profile state control: constants, states, codes
package dpsc_pkg;
   localparam logic [15:0] CW_SHUTDOWN = 16'h0006;
   localparam logic [15:0] CW_SWITCH_ON = 16'h0007;
   localparam logic [15:0] CW_ENABLE = 16'h000F;
   localparam logic [15:0] CW_DISABLE = 16'h0000;
   localparam logic [15:0] CW_QUICK_STOP = 16'h0002;
   localparam logic [15:0] CW_FAULT_RESET = 16'h0080;
   localparam logic [15:0] SW_INIT = 16'h0000;
   localparam logic [15:0] SW_NO_FAULT = 16'h0250;
   localparam logic [15:0] SW_READY = 16'h0231;
   localparam logic [15:0] SW_WAIT_ON = 16'h0233;
   localparam logic [15:0] SW_RUNNING = 16'h0237;
   localparam logic [15:0] SW_QUICK_STOP = 16'h0217;
   localparam logic [15:0] SW_STOP_FAULT = 16'h021F;
   localparam logic [15:0] SW_FAULT = 16'h0218;
   // Register offsets
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h1;
   localparam logic [3:0] ADDR_NUMER = 4'h2;
   localparam logic [3:0] ADDR_DENOM = 4'h3;
   localparam logic [3:0] ADDR_CONFIG = 4'h4;
   localparam logic [3:0] ADDR_FEEDBACK = 4'h5;
   localparam logic [3:0] ADDR_MOTOR_POS = 4'h6;
   localparam logic [3:0] ADDR_FLAGS = 4'h7;
   // Config fields: bits 4:0 encoder bits, 7:5 encoder type, 10:8 quick-stop option
   localparam int CFG_BITS_LSB = 0;
   localparam int CFG_TYPE_LSB = 5;
   localparam int CFG_QSO_LSB = 8;
   localparam logic [2:0] ENC_INCREMENTAL = 3'h0;
   localparam logic [2:0] ENC_RESOLVER = 3'h1;
   localparam logic [2:0] ENC_ABS = 3'h2;
   localparam logic [23:0] INC_INCREMENTAL = 24'h002710;
   localparam logic [23:0] INC_RESOLVER = 24'h010000;
   // Reset values
   localparam logic [31:0] NUMER_RESET = 32'h00000001;
   localparam logic [31:0] DENOM_RESET = 32'h00000001;
   localparam logic [15:0] CONFIG_RESET = 16'h0211;
   // Ratio limits: ratio >= 1/1000, ratio <= limit
   localparam logic [15:0] RATIO_MIN_DIV = 16'h03E8;
   localparam logic [16:0] LIMIT_BASE = 17'h00FA0;
   localparam logic [4:0] LIMIT_BASE_BITS = 5'h14;
   // Timing
   localparam int INIT_TIME_US = 10;
   localparam int STOP_TIME_US = 5;
   localparam int CLK_MHZ = 20;
   localparam logic [7:0] INIT_CYCLES = 8'(INIT_TIME_US * CLK_MHZ);
   localparam logic [7:0] STOP_CYCLES = 8'(STOP_TIME_US * CLK_MHZ);
   typedef enum logic [2:0] {
      ST_INIT = 3'b000,
      ST_NO_FAULT = 3'b001,
      ST_READY = 3'b010,
      ST_WAIT_ON = 3'b011,
      ST_RUNNING = 3'b100,
      ST_QUICK_STOP = 3'b101,
      ST_STOP_FAULT = 3'b110,
      ST_FAULT = 3'b111
   } dpsc_state_type;
endpackage : dpsc_pkg

// ### rtl/dpsc_top.sv
// Drive power state machine, gear ratio and its range check
//
// Notes on behaviour
// - User units become increments as numerator over denominator.
// - Increments per revolution follow encoder type and bit count.
// - Below 20 bits, gear ratio must lie within 0.001 to 4000.
// - 21 to 24 bits allow 8000, 16000, 32000, 64000; lower limit 0.001.
// - Out-of-range ratio raises the gear ratio error alarm.
// - Motor position equals shaft position times gear ratio.
// - Start in Initialization, status 0000; then No Fault, status 0250.
// - Error during initialization goes straight to stop-at-fault.
// - Word 0006 from No Fault, Wait or Running enters Ready, 0231.
// - Word 0007 from Ready or Running enters Wait-to-switch-on, 0233.
// - Word 000F in Wait enters Running, motor energized, 0237.
// - Word 0000 in Ready or Wait returns to No Fault, 0250.
// - Word 0002 in Running enters Quick Stop, 0217.
// - Option 0, 1, 2: Quick Stop ends in No Fault after stopping.
// - Option 5, 6: hold Quick Stop; word 000F then returns to Running.
// - Fault outside Fault state enters stop-at-fault, motor off, 021F.
// - Stop-at-fault completes into Fault, drive inhibited, 0218.
// - Fault allows parameter writes; word 0080 clears to No Fault.
// - Parameter writes refused only in Initialization; drive inhibited there and in Fault.
`timescale 1ns/1ps
module dpsc_top (
   input wire logic clk,
   input wire logic reset,
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic fault_in,
   input wire logic stop_done,
   input wire logic [31:0] shaft_pos,
   output logic [31:0] rdata,
   output logic [15:0] status_word,
   output logic motor_energized,
   output logic drive_inhibit,
   output logic gear_ratio_error_alarm,
   output logic [23:0] inc_per_rev,
   output logic param_refused
);
   typedef struct packed {
      dpsc_pkg::dpsc_state_type state;
      logic [15:0] control;
      logic cw_new;
      logic [31:0] numer;
      logic [31:0] denom;
      logic [15:0] setup;
      logic [31:0] shaft;
      logic [63:0] motor_pos;
      logic [7:0] count;
      logic [2:0] fault_sync;
      logic [2:0] done_sync;
      logic fault_level;
      logic done_level;
      logic [31:0] rdata;
      logic [15:0] status_word;
      logic motor_energized;
      logic drive_inhibit;
      logic alarm;
      logic [23:0] inc_per_rev;
      logic param_refused;
   } dpsc_regs_type;

   dpsc_regs_type r;
   dpsc_regs_type next_r;

   function automatic logic [15:0] dpsc_status_of(input dpsc_pkg::dpsc_state_type s);
      unique case (s)
         dpsc_pkg::ST_INIT: dpsc_status_of = dpsc_pkg::SW_INIT;
         dpsc_pkg::ST_NO_FAULT: dpsc_status_of = dpsc_pkg::SW_NO_FAULT;
         dpsc_pkg::ST_READY: dpsc_status_of = dpsc_pkg::SW_READY;
         dpsc_pkg::ST_WAIT_ON: dpsc_status_of = dpsc_pkg::SW_WAIT_ON;
         dpsc_pkg::ST_RUNNING: dpsc_status_of = dpsc_pkg::SW_RUNNING;
         dpsc_pkg::ST_QUICK_STOP: dpsc_status_of = dpsc_pkg::SW_QUICK_STOP;
         dpsc_pkg::ST_STOP_FAULT: dpsc_status_of = dpsc_pkg::SW_STOP_FAULT;
         dpsc_pkg::ST_FAULT: dpsc_status_of = dpsc_pkg::SW_FAULT;
      endcase
   endfunction : dpsc_status_of

   // Upper limit for the encoder: 4000 up to 20 bits, doubling per bit above
   function automatic logic [16:0] dpsc_limit(input logic [4:0] bits);
      if (bits <= dpsc_pkg::LIMIT_BASE_BITS) begin
         dpsc_limit = dpsc_pkg::LIMIT_BASE;
      end else begin
         dpsc_limit = 17'(dpsc_pkg::LIMIT_BASE << (bits - dpsc_pkg::LIMIT_BASE_BITS));
      end
   endfunction : dpsc_limit

   logic [4:0] enc_bits;
   logic [2:0] enc_type;
   logic [2:0] qs_option;
   logic [16:0] limit;
   logic [63:0] hi_prod;
   logic [63:0] lo_prod;
   logic ratio_bad;
   logic fault_seen;
   logic done_seen;
   logic cw_take;

   always_comb begin
      enc_bits = r.setup[dpsc_pkg::CFG_BITS_LSB +: 5];
      enc_type = r.setup[dpsc_pkg::CFG_TYPE_LSB +: 3];
      qs_option = r.setup[dpsc_pkg::CFG_QSO_LSB +: 3];
      limit = dpsc_limit(enc_bits);
      // Cross-multiplied so no divider is needed
      lo_prod = 64'(r.numer) * 64'(dpsc_pkg::RATIO_MIN_DIV);
      hi_prod = 64'(r.denom) * 64'(limit);
      ratio_bad = (r.denom == 32'h00000000) || (lo_prod < 64'(r.denom)) || (64'(r.numer) > hi_prod);
      // Second and third stage agree before a pin change counts
      fault_seen = (r.fault_sync[1] == r.fault_sync[2]) ? r.fault_sync[2] : r.fault_level;
      done_seen = (r.done_sync[1] == r.done_sync[2]) ? r.done_sync[2] : r.done_level;
      cw_take = r.cw_new;
   end

   always_comb begin
      next_r = r;
      next_r.fault_sync = {r.fault_sync[1:0], fault_in};
      next_r.done_sync = {r.done_sync[1:0], stop_done};
      next_r.fault_level = fault_seen;
      next_r.done_level = done_seen;
      next_r.cw_new = 1'b0;
      next_r.param_refused = 1'b0;
      next_r.rdata = 32'h00000000;
      // Bus writes
      if (wr) begin
         if (addr == dpsc_pkg::ADDR_CONTROL) begin
            next_r.control = wdata[15:0];
            next_r.cw_new = 1'b1;
         end else if (addr == dpsc_pkg::ADDR_NUMER || addr == dpsc_pkg::ADDR_DENOM
                      || addr == dpsc_pkg::ADDR_CONFIG) begin
            if (r.state == dpsc_pkg::ST_INIT) begin
               next_r.param_refused = 1'b1;
            end else if (addr == dpsc_pkg::ADDR_NUMER) begin
               next_r.numer = wdata;
            end else if (addr == dpsc_pkg::ADDR_DENOM) begin
               next_r.denom = wdata;
            end else begin
               next_r.setup = wdata[15:0];
            end
         end
      end
      // Bus reads, data in next cycle
      if (rd) begin
         unique case (addr)
            dpsc_pkg::ADDR_CONTROL: next_r.rdata = {16'h0000, r.control};
            dpsc_pkg::ADDR_STATUS: next_r.rdata = {16'h0000, r.status_word};
            dpsc_pkg::ADDR_NUMER: next_r.rdata = r.numer;
            dpsc_pkg::ADDR_DENOM: next_r.rdata = r.denom;
            dpsc_pkg::ADDR_CONFIG: next_r.rdata = {16'h0000, r.setup};
            dpsc_pkg::ADDR_FEEDBACK: next_r.rdata = r.shaft;
            dpsc_pkg::ADDR_MOTOR_POS: next_r.rdata = r.motor_pos[31:0];
            dpsc_pkg::ADDR_FLAGS: next_r.rdata = {29'h0, r.alarm, r.drive_inhibit, r.motor_energized};
            default: next_r.rdata = 32'h00000000;
         endcase
      end
      // Position feedback scaled into increments, truncated toward zero
      next_r.shaft = shaft_pos;
      next_r.motor_pos = (r.denom == 32'h00000000) ? 64'h0 : (64'(r.shaft) * 64'(r.numer)) / 64'(r.denom);
      unique case (enc_type)
         dpsc_pkg::ENC_INCREMENTAL: next_r.inc_per_rev = dpsc_pkg::INC_INCREMENTAL;
         dpsc_pkg::ENC_RESOLVER: next_r.inc_per_rev = dpsc_pkg::INC_RESOLVER;
         dpsc_pkg::ENC_ABS: next_r.inc_per_rev = 24'(25'h0000001 << enc_bits);
         default: next_r.inc_per_rev = dpsc_pkg::INC_INCREMENTAL;
      endcase
      next_r.alarm = ratio_bad;
      if (r.count != 8'h00) begin
         next_r.count = r.count - 8'h01;
      end
      // Power state machine
      if (fault_seen && r.state != dpsc_pkg::ST_FAULT && r.state != dpsc_pkg::ST_STOP_FAULT) begin
         next_r.state = dpsc_pkg::ST_STOP_FAULT;
         next_r.count = dpsc_pkg::STOP_CYCLES;
      end else begin
         unique case (r.state)
            dpsc_pkg::ST_INIT: begin
               if (r.count == 8'h00) begin
                  next_r.state = dpsc_pkg::ST_NO_FAULT;
               end
            end
            dpsc_pkg::ST_NO_FAULT: begin
               if (cw_take && r.control == dpsc_pkg::CW_SHUTDOWN) begin
                  next_r.state = dpsc_pkg::ST_READY;
               end
            end
            dpsc_pkg::ST_READY: begin
               if (cw_take && r.control == dpsc_pkg::CW_SWITCH_ON) begin
                  next_r.state = dpsc_pkg::ST_WAIT_ON;
               end else if (cw_take && r.control == dpsc_pkg::CW_DISABLE) begin
                  next_r.state = dpsc_pkg::ST_NO_FAULT;
               end
            end
            dpsc_pkg::ST_WAIT_ON: begin
               if (cw_take && r.control == dpsc_pkg::CW_ENABLE) begin
                  next_r.state = dpsc_pkg::ST_RUNNING;
               end else if (cw_take && r.control == dpsc_pkg::CW_SHUTDOWN) begin
                  next_r.state = dpsc_pkg::ST_READY;
               end else if (cw_take && r.control == dpsc_pkg::CW_DISABLE) begin
                  next_r.state = dpsc_pkg::ST_NO_FAULT;
               end
            end
            dpsc_pkg::ST_RUNNING: begin
               if (cw_take && r.control == dpsc_pkg::CW_SWITCH_ON) begin
                  next_r.state = dpsc_pkg::ST_WAIT_ON;
               end else if (cw_take && r.control == dpsc_pkg::CW_SHUTDOWN) begin
                  next_r.state = dpsc_pkg::ST_READY;
               end else if (cw_take && r.control == dpsc_pkg::CW_QUICK_STOP) begin
                  next_r.state = dpsc_pkg::ST_QUICK_STOP;
                  next_r.count = dpsc_pkg::STOP_CYCLES;
               end
            end
            dpsc_pkg::ST_QUICK_STOP: begin
               // Stop completes on the minimum time and the stopped pin
               if (r.count == 8'h00 && done_seen) begin
                  if (qs_option <= 3'h2) begin
                     next_r.state = dpsc_pkg::ST_NO_FAULT;
                  end else if (cw_take && r.control == dpsc_pkg::CW_ENABLE) begin
                     next_r.state = dpsc_pkg::ST_RUNNING;
                  end
               end
            end
            dpsc_pkg::ST_STOP_FAULT: begin
               if (r.count == 8'h00 && done_seen) begin
                  next_r.state = dpsc_pkg::ST_FAULT;
               end
            end
            dpsc_pkg::ST_FAULT: begin
               // Reset ignored while the fault pin still stands
               if (cw_take && r.control == dpsc_pkg::CW_FAULT_RESET && !fault_seen) begin
                  next_r.state = dpsc_pkg::ST_NO_FAULT;
               end
            end
         endcase
      end
      next_r.status_word = dpsc_status_of(next_r.state);
      next_r.motor_energized = (next_r.state == dpsc_pkg::ST_RUNNING)
                               || (next_r.state == dpsc_pkg::ST_QUICK_STOP);
      next_r.drive_inhibit = (next_r.state == dpsc_pkg::ST_FAULT)
                             || (next_r.state == dpsc_pkg::ST_INIT);
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         r <= '0;
         r.state <= dpsc_pkg::ST_INIT;
         r.numer <= dpsc_pkg::NUMER_RESET;
         r.denom <= dpsc_pkg::DENOM_RESET;
         r.setup <= dpsc_pkg::CONFIG_RESET;
         r.count <= dpsc_pkg::INIT_CYCLES;
         r.status_word <= dpsc_pkg::SW_INIT;
         r.drive_inhibit <= 1'b1;
         r.inc_per_rev <= dpsc_pkg::INC_INCREMENTAL;
      end else begin
         r <= next_r;
      end
   end

   assign rdata = r.rdata;
   assign status_word = r.status_word;
   assign motor_energized = r.motor_energized;
   assign drive_inhibit = r.drive_inhibit;
   assign gear_ratio_error_alarm = r.alarm;
   assign inc_per_rev = r.inc_per_rev;
   assign param_refused = r.param_refused;

   ready_from_nofault_a: assert property (@(posedge clk) disable iff (reset)
      (r.state == dpsc_pkg::ST_NO_FAULT && r.cw_new && r.control == dpsc_pkg::CW_SHUTDOWN && !fault_seen)
      |=> (status_word == dpsc_pkg::SW_READY))
      else $error("shutdown word did not give ready");
   wait_from_ready_a: assert property (@(posedge clk) disable iff (reset)
      (r.state == dpsc_pkg::ST_READY && r.cw_new && r.control == dpsc_pkg::CW_SWITCH_ON && !fault_seen)
      |=> (status_word == dpsc_pkg::SW_WAIT_ON))
      else $error("switch on word did not give wait");
   run_enable_a: assert property (@(posedge clk) disable iff (reset)
      (r.state == dpsc_pkg::ST_WAIT_ON && r.cw_new && r.control == dpsc_pkg::CW_ENABLE && !fault_seen)
      |=> (status_word == dpsc_pkg::SW_RUNNING && motor_energized))
      else $error("enable word did not energize");
   quick_stop_a: assert property (@(posedge clk) disable iff (reset)
      (r.state == dpsc_pkg::ST_RUNNING && r.cw_new && r.control == dpsc_pkg::CW_QUICK_STOP && !fault_seen)
      |=> (status_word == dpsc_pkg::SW_QUICK_STOP))
      else $error("quick stop word not obeyed");
   fault_entry_a: assert property (@(posedge clk) disable iff (reset)
      (fault_seen && r.state != dpsc_pkg::ST_FAULT) |=> (status_word == dpsc_pkg::SW_STOP_FAULT
      || status_word == dpsc_pkg::SW_FAULT))
      else $error("fault did not reach stop-at-fault");
   fault_inhibit_a: assert property (@(posedge clk) disable iff (reset)
      (status_word == dpsc_pkg::SW_FAULT) |-> (drive_inhibit && !motor_energized))
      else $error("fault state not inhibited");
   init_refuse_a: assert property (@(posedge clk) disable iff (reset)
      (r.state == dpsc_pkg::ST_INIT && wr && addr == dpsc_pkg::ADDR_NUMER)
      |=> (param_refused && $stable(r.numer)))
      else $error("write accepted in initialization");
   unmatched_word_a: assert property (@(posedge clk) disable iff (reset)
      (r.cw_new && r.state == dpsc_pkg::ST_NO_FAULT && r.control != dpsc_pkg::CW_SHUTDOWN && !fault_seen)
      |=> $stable(status_word))
      else $error("unmatched word changed state");
   alarm_range_a: assert property (@(posedge clk) disable iff (reset)
      ratio_bad |=> gear_ratio_error_alarm)
      else $error("ratio out of range without alarm");
   // Further transitions (both disable paths share one), then refusal, motor power and ratio range checks
   init_done_a: assert property (@(posedge clk) disable iff (reset)
      (r.state == dpsc_pkg::ST_INIT && r.count == 8'h00
      && !fault_seen)
      |=> (status_word == dpsc_pkg::SW_NO_FAULT))
      else $error("initialization did not end");
   init_fault_a: assert property (@(posedge clk) disable iff (reset)
      (r.state == dpsc_pkg::ST_INIT
      && fault_seen)
      |=> (status_word == dpsc_pkg::SW_STOP_FAULT))
      else $error("fault in initialization missed");
   ready_from_wait_a: assert property (@(posedge clk) disable iff (reset)
      (r.state == dpsc_pkg::ST_WAIT_ON && r.cw_new
      && r.control == dpsc_pkg::CW_SHUTDOWN && !fault_seen)
      |=> (status_word == dpsc_pkg::SW_READY))
      else $error("shutdown word ignored in wait");
   wait_from_run_a: assert property (@(posedge clk) disable iff (reset)
      (r.state == dpsc_pkg::ST_RUNNING && r.cw_new
      && r.control == dpsc_pkg::CW_SWITCH_ON && !fault_seen)
      |=> (status_word == dpsc_pkg::SW_WAIT_ON))
      else $error("switch on word ignored in running");
   disable_word_a: assert property (@(posedge clk) disable iff (reset)
      ((r.state == dpsc_pkg::ST_READY || r.state == dpsc_pkg::ST_WAIT_ON) && r.cw_new
      && r.control == dpsc_pkg::CW_DISABLE && !fault_seen)
      |=> (status_word == dpsc_pkg::SW_NO_FAULT))
      else $error("disable word not obeyed");
   stop_fall_back_a: assert property (@(posedge clk) disable iff (reset)
      (r.state == dpsc_pkg::ST_QUICK_STOP && r.count == 8'h00 && done_seen
      && qs_option <= 3'h2 && !fault_seen)
      |=> (status_word == dpsc_pkg::SW_NO_FAULT))
      else $error("quick stop did not fall back");
   stop_hold_a: assert property (@(posedge clk) disable iff (reset)
      (r.state == dpsc_pkg::ST_QUICK_STOP && (qs_option == 3'h5 || qs_option == 3'h6)
      && !(r.cw_new && r.control == dpsc_pkg::CW_ENABLE) && !fault_seen)
      |=> (status_word == dpsc_pkg::SW_QUICK_STOP))
      else $error("quick stop not held");
   stop_resume_a: assert property (@(posedge clk) disable iff (reset)
      (r.state == dpsc_pkg::ST_QUICK_STOP && r.count == 8'h00 && done_seen && (qs_option == 3'h5
      || qs_option == 3'h6) && r.cw_new && r.control == dpsc_pkg::CW_ENABLE && !fault_seen)
      |=> (status_word == dpsc_pkg::SW_RUNNING && motor_energized))
      else $error("quick stop did not resume");
   fault_reached_a: assert property (@(posedge clk) disable iff (reset)
      (r.state == dpsc_pkg::ST_STOP_FAULT && r.count == 8'h00
      && done_seen)
      |=> (status_word == dpsc_pkg::SW_FAULT))
      else $error("stop at fault did not end");
   fault_clear_a: assert property (@(posedge clk) disable iff (reset)
      (r.state == dpsc_pkg::ST_FAULT && r.cw_new
      && r.control == dpsc_pkg::CW_FAULT_RESET && !fault_seen)
      |=> (status_word == dpsc_pkg::SW_NO_FAULT))
      else $error("fault reset word not obeyed");
   refuse_init_only_a: assert property (@(posedge clk) disable iff (reset)
      (r.state != dpsc_pkg::ST_INIT
      && wr)
      |=> !param_refused)
      else $error("write refused outside initialization");
   motor_power_a: assert property (@(posedge clk) disable iff (reset)
      (status_word == dpsc_pkg::SW_RUNNING
      || status_word == dpsc_pkg::SW_STOP_FAULT)
      |-> (motor_energized == (status_word == dpsc_pkg::SW_RUNNING)))
      else $error("motor power wrong for state");
   low_bits_range_a: assert property (@(posedge clk) disable iff (reset)
      (enc_bits < 5'h14 && (64'(r.numer) > 64'(r.denom) * 64'h0FA0
      || 64'(r.numer) * 64'h03E8 < 64'(r.denom)))
      |=> gear_ratio_error_alarm)
      else $error("low resolution ratio not flagged");
   high_bits_range_a: assert property (@(posedge clk) disable iff (reset)
      (enc_bits == 5'h18 && r.denom != 32'h00000000 && 64'(r.numer) <= 64'(r.denom) * 64'h0FA00
      && 64'(r.numer) * 64'h03E8 >= 64'(r.denom))
      |=> !gear_ratio_error_alarm)
      else $error("legal high resolution ratio flagged");
endmodule : dpsc_top

// ### dv/dpsc_host.sv
// Host controller model: register bus master for the drive block
`timescale 1ns/1ps
module dpsc_host (
   input wire logic clk,
   input wire logic [31:0] rdata,
   output logic [3:0] addr,
   output logic [31:0] wdata,
   output logic wr,
   output logic rd
);
   initial begin
      addr = 4'h0;
      wdata = 32'h0;
      wr = 1'b0;
      rd = 1'b0;
   end
   // One-cycle write; data inverted afterwards so stale values never look valid
   task automatic write(input logic [3:0] a, input logic [31:0] w);
      @(posedge clk);
      addr <= a;
      wdata <= w;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      wdata <= ~w;
   endtask : write
   // Read data stands only in the cycle after the strobe
   task automatic read(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      v = rdata;
   endtask : read
endmodule : dpsc_host

// ### dv/test_drive_profile_state_control.sv
// Testbench: state machine, gear ratio check and fault handling against a model
`timescale 1ns/1ps
module test_drive_profile_state_control;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [3:0] addr;
   logic [31:0] wdata;
   logic wr;
   logic rd;
   logic fault_in = 1'b0;
   logic stop_done = 1'b0;
   logic [31:0] shaft_pos = 32'h0;
   logic [31:0] rdata;
   logic [15:0] status_word;
   logic motor_energized;
   logic drive_inhibit;
   logic gear_ratio_error_alarm;
   logic [23:0] inc_per_rev;
   logic param_refused;
   int errors = 0;
   int checked = 0;
   int cycles = 0;
   int ms = 0;
   logic [31:0] lf = 32'h00017D66;
   logic [31:0] v;
   longint n;
   longint d;
   longint g;
   longint lim;
   logic [15:0] cfg;
   // Unmatched code 1234 checks that stray words change nothing
   logic [15:0] words [7] = '{dpsc_pkg::CW_DISABLE, dpsc_pkg::CW_QUICK_STOP, dpsc_pkg::CW_SHUTDOWN,
      dpsc_pkg::CW_SWITCH_ON, dpsc_pkg::CW_ENABLE, dpsc_pkg::CW_FAULT_RESET, 16'h1234};
   logic [15:0] cfgs [8] = '{16'h0011, 16'h0031, 16'h0051, 16'h0054, 16'h0055, 16'h0056, 16'h0057, 16'h0058};
   logic [15:0] seq [4] = '{16'h0006, 16'h0007, 16'h000F, 16'h0002};
   logic [2:0] opts [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
   dpsc_host i_dpsc_host (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
   dpsc_top i_dpsc_top (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .fault_in(fault_in), .stop_done(stop_done), .shaft_pos(shaft_pos), .rdata(rdata),
      .status_word(status_word), .motor_energized(motor_energized), .drive_inhibit(drive_inhibit),
      .gear_ratio_error_alarm(gear_ratio_error_alarm), .inc_per_rev(inc_per_rev), .param_refused(param_refused));
   initial begin
      forever #25 clk = ~clk;
   end
   function automatic logic [31:0] lfsr(logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   function automatic longint gcd(longint a, longint b);
      longint t;
      while (b != 0) begin
         t = a % b;
         a = b;
         b = t;
      end
      return a;
   endfunction : gcd
   // Quick stop completion is handled outside, since it needs the stopped pin
   function automatic int step(int s, logic [15:0] cw);
      case (cw)
         16'h0006: if (s == 'h250 || s == 'h233 || s == 'h237) return 'h231;
         16'h0007: if (s == 'h231 || s == 'h237) return 'h233;
         16'h000F: if (s == 'h233) return 'h237;
         16'h0000: if (s == 'h231 || s == 'h233) return 'h250;
         16'h0002: if (s == 'h237) return 'h217;
         16'h0080: if (s == 'h218) return 'h250;
         default: return s;
      endcase
      return s;
   endfunction : step
   task automatic test_done();
      if (errors == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_state();
      repeat (3) @(posedge clk);
      chk({16'h0, status_word}, 32'(ms));
      chk({31'h0, motor_energized}, 32'(ms == 'h237 || ms == 'h217));
      chk({31'h0, drive_inhibit}, 32'(ms == 'h0 || ms == 'h218));
   endtask : chk_state
   task automatic send(input logic [15:0] w);
      i_dpsc_host.write(dpsc_pkg::ADDR_CONTROL, {16'h0, w});
      ms = step(ms, w);
      chk_state();
   endtask : send
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         test_done();
      end
   end
   initial begin
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      chk_state();
      i_dpsc_host.write(dpsc_pkg::ADDR_NUMER, 32'h2);
      @(posedge clk);
      chk({31'h0, param_refused}, 32'h1);
      repeat (200) @(posedge clk);
      ms = 'h250;
      chk_state();
      i_dpsc_host.write(dpsc_pkg::ADDR_NUMER, 32'h1);
      @(posedge clk);
      chk({31'h0, param_refused}, 32'h0);
      for (int i = 0; i < 40; i++) begin
         lf = lfsr(lf);
         send(words[lf % 7]);
      end
      // Each option: run, quick stop, then either fall back or hold
      for (int i = 0; i < 5; i++) begin
         i_dpsc_host.write(dpsc_pkg::ADDR_CONFIG, {21'h0, opts[i], 8'h11});
         stop_done <= 1'b1;
         repeat (110) @(posedge clk);
         ms = (ms == 'h217) ? 'h250 : ms;
         stop_done <= 1'b0;
         foreach (seq[k]) send(seq[k]);
         stop_done <= 1'b1;
         repeat (110) @(posedge clk);
         ms = (opts[i] > 3'h2) ? 'h217 : 'h250;
         chk_state();
         if (opts[i] > 3'h2) begin
            i_dpsc_host.write(dpsc_pkg::ADDR_CONTROL, 32'hF);
            ms = 'h237;
            chk_state();
         end
         stop_done <= 1'b0;
      end
      foreach (cfgs[c]) begin
         cfg = cfgs[c];
         i_dpsc_host.write(dpsc_pkg::ADDR_CONFIG, {16'h0, cfg});
         lim = (cfg[4:0] <= 5'h14) ? 4000 : 4000 << (cfg[4:0] - 5'h14);
         repeat (3) @(posedge clk);
         if (cfg[4:0] != 5'h18) begin
            chk({8'h0, inc_per_rev}, cfg[7:5] == 3'h0 ? 32'h00002710 : cfg[7:5] == 3'h1 ? 32'h00010000 :
               32'h1 << cfg[4:0]);
         end
         for (int j = 0; j < 7; j++) begin
            n = (j < 2) ? lim + j : 1;
            d = (j < 2) ? 1 : 1000 + j - 2;
            if (j > 3) begin
               lf = lfsr(lf);
               n = longint'(lf[15:0] >> lf[19:16]);
               d = 1 + longint'(lf[31:20]);
            end
            g = gcd(n, d);
            n = n / g;
            d = d / g;
            i_dpsc_host.write(dpsc_pkg::ADDR_NUMER, 32'(n));
            i_dpsc_host.write(dpsc_pkg::ADDR_DENOM, 32'(d));
            shaft_pos <= {16'h0, lf[27:12]};
            repeat (3) @(posedge clk);
            chk({31'h0, gear_ratio_error_alarm}, 32'(n * 1000 < d || n > d * lim));
            i_dpsc_host.read(dpsc_pkg::ADDR_MOTOR_POS, v);
            chk(v, 32'((longint'(shaft_pos) * n) / d));
         end
      end
      i_dpsc_host.read(4'hF, v);
      chk(v, 32'h0);
      i_dpsc_host.read(dpsc_pkg::ADDR_STATUS, v);
      chk(v, 32'(ms));
      fault_in <= 1'b1;
      repeat (5) @(posedge clk);
      ms = 'h21F;
      chk_state();
      stop_done <= 1'b1;
      repeat (110) @(posedge clk);
      ms = 'h218;
      chk_state();
      stop_done <= 1'b0;
      i_dpsc_host.write(dpsc_pkg::ADDR_NUMER, 32'h1);
      @(posedge clk);
      chk({31'h0, param_refused}, 32'h0);
      fault_in <= 1'b0;
      repeat (5) @(posedge clk);
      send(dpsc_pkg::CW_FAULT_RESET);
      fault_in <= 1'b1;
      reset <= 1'b1;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      repeat (8) @(posedge clk);
      ms = 'h21F;
      chk_state();
      test_done();
   end
endmodule : test_drive_profile_state_control
